// file: design/pfm_pkg.sv
package pfm_pkg;

  localparam int PFM_NUM_PADS = 39;
  localparam int PFM_NUM_SLOTS = 5;
  localparam int PFM_SEL_W = 3;
  localparam logic [PFM_SEL_W-1:0] PFM_SEL_MAX = 3'h4;
  localparam int PFM_FN_W = 6;
  localparam int PFM_NUM_FNS = 49;

  // Flag bit positions returned by pfm_fn_flags
  localparam int PFM_FL_IN = 3;
  localparam int PFM_FL_OUT = 2;
  localparam int PFM_FL_TRI = 1;
  localparam int PFM_FL_HIGH = 0;
  localparam int PFM_FL_W = 4;

  localparam logic PFM_RST_PAD_OUT = 1'h0;
  localparam logic PFM_RST_OE_B = 1'h1;
  localparam logic PFM_MTX_IDLE_IN = 1'h0;

  typedef enum logic [PFM_FN_W-1:0] {
    FN_NONE, FN_MATRIX,
    S0_TX, S0_RX, S0_RTS, S0_CTS, S1_TX, S1_RX, S1_RTS, S1_CTS,
    DBG_CLK, DBG_DIN, DBG_DOUT, DBG_MS,
    MEM_DOUT, MEM_DIN, MEM_HOLD, MEM_WP, MEM_CLK, MEM_CS,
    MEM_UP4, MEM_UP5, MEM_UP6, MEM_UP7, MEM_DQS, MEM_CLKN, MEM_CLKP,
    AUX_DOUT, AUX_DIN, AUX_HOLD, AUX_WP, AUX_CLK, AUX_CS, AUX_CLKN, AUX_CLKP,
    FST_DOUT, FST_DIN, FST_HOLD, FST_WP, FST_CLK, FST_CS,
    FST_UP4, FST_UP5, FST_UP6, FST_UP7, FST_DQS,
    CK_OUT1, CK_OUT2, CK_OUT3
  } pfm_fn_type;

  // {can input, can output, may tri-state, input idles high}
  function automatic logic [PFM_FL_W-1:0] pfm_fn_flags(input pfm_fn_type f);
    logic [PFM_FL_W-1:0] r;
    r = 4'h0;
    unique case (f)
      S0_TX, S0_RTS, S1_TX, S1_RTS, CK_OUT1, CK_OUT2, CK_OUT3: r = 4'h4;
      S0_RX, S0_CTS, S1_RX, S1_CTS, DBG_CLK, DBG_DIN, DBG_MS: r = 4'h9;
      DBG_DOUT, MEM_CLK, MEM_CS, MEM_CLKN, MEM_CLKP, AUX_CLK, AUX_CS,
      AUX_CLKN, AUX_CLKP, FST_DQS: r = 4'h6;
      MEM_DQS: r = 4'he;
      MEM_DOUT, MEM_DIN, MEM_HOLD, MEM_WP, MEM_UP4, MEM_UP5, MEM_UP6, MEM_UP7,
      AUX_DOUT, AUX_DIN, AUX_HOLD, AUX_WP, FST_DOUT, FST_DIN, FST_HOLD, FST_WP,
      FST_CLK, FST_CS, FST_UP4, FST_UP5, FST_UP6, FST_UP7: r = 4'hf;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  localparam pfm_fn_type PFM_PAD_MAP [PFM_NUM_PADS][PFM_NUM_SLOTS] = '{
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FST_UP4, AUX_HOLD, FST_HOLD},
    '{FN_MATRIX, FN_MATRIX, FST_UP5, AUX_CS, FST_CS},
    '{FN_MATRIX, FN_MATRIX, FST_UP6, AUX_DIN, FST_DIN},
    '{FN_MATRIX, FN_MATRIX, FST_UP7, AUX_CLK, FST_CLK},
    '{FN_MATRIX, FN_MATRIX, FST_DQS, AUX_DOUT, FST_DOUT},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, AUX_WP, FST_WP},
    '{FN_MATRIX, FN_MATRIX, S0_RTS, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, S0_CTS, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, S1_TX, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, S1_RX, CK_OUT3, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, S1_RTS, CK_OUT2, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, S1_CTS, CK_OUT1, FN_NONE},
    '{MEM_HOLD, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{MEM_WP, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{MEM_CS, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{MEM_CLK, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{MEM_DOUT, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{MEM_DIN, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, MEM_UP4},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, MEM_UP5},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, MEM_UP6},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, MEM_UP7},
    '{FN_MATRIX, FN_MATRIX, FN_NONE, FN_NONE, MEM_DQS},
    '{DBG_CLK, FN_MATRIX, CK_OUT3, FN_NONE, FN_NONE},
    '{DBG_DOUT, FN_MATRIX, CK_OUT2, FN_NONE, FN_NONE},
    '{DBG_DIN, FN_MATRIX, CK_OUT1, FN_NONE, FN_NONE},
    '{DBG_MS, FN_MATRIX, FN_NONE, FN_NONE, FN_NONE},
    '{S0_TX, FN_MATRIX, CK_OUT1, FN_NONE, FN_NONE},
    '{S0_RX, FN_MATRIX, CK_OUT2, FN_NONE, FN_NONE},
    '{MEM_CLKP, FN_MATRIX, AUX_CLKP, FN_NONE, FN_NONE},
    '{MEM_CLKN, FN_MATRIX, AUX_CLKN, FN_NONE, FN_NONE}
  };

endpackage

// file: design/pfm_pad_function_selector.sv
`timescale 1ns/1ps

// Function
// - Each pad takes at most one of five functions
// - Some slots route through the programmable matrix
// - Matrix path carries one extra cycle latency
// - Other slots wire directly to fixed peripherals
// - Debug port clock, data in/out, mode select
// - Memory bus six lines, single/dual/quad
// - Memory bus octal: upper data plus strobe
// - Memory bus differential clock pair
// - Auxiliary memory bus six lines
// - Auxiliary memory bus differential clock pair
// - Fast port six lines, single/dual/quad
// - Fast port octal: upper data plus strobe
// - Clock outputs drive pads, output only
// - Unselected default-high inputs read as one
// - Function types: input, output, high impedance
module pfm_pad_function_selector
  import pfm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [PFM_SEL_W-1:0] pad_sel [PFM_NUM_PADS],
  input wire logic [PFM_NUM_PADS-1:0] pad_in,
  output logic [PFM_NUM_PADS-1:0] pad_out,
  output logic [PFM_NUM_PADS-1:0] pad_oe_b,
  input wire logic [PFM_NUM_FNS-1:0] fn_out,
  input wire logic [PFM_NUM_FNS-1:0] fn_oe,
  output logic [PFM_NUM_FNS-1:0] fn_in,
  input wire logic [PFM_NUM_PADS-1:0] mtx_out,
  input wire logic [PFM_NUM_PADS-1:0] mtx_oe,
  output logic [PFM_NUM_PADS-1:0] mtx_in
);

  pfm_fn_type sel_fn [PFM_NUM_PADS];
  logic [PFM_NUM_PADS-1:0] sel_ok;
  logic [PFM_NUM_PADS-1:0] sel_in;
  logic [PFM_NUM_PADS-1:0] is_mtx;
  logic [PFM_NUM_PADS-1:0] dir_drive;
  logic [PFM_NUM_PADS-1:0] dir_val;
  logic [PFM_NUM_PADS-1:0] next_pad_out;
  logic [PFM_NUM_PADS-1:0] next_oe_b;
  logic [PFM_NUM_PADS-1:0] next_mtx_in;
  logic [PFM_NUM_PADS-1:0] mtx_out_q;
  logic [PFM_NUM_PADS-1:0] mtx_oe_q;
  logic [PFM_NUM_PADS-1:0] mtx_in_q;
  logic [PFM_NUM_FNS-1:0] fn_hit;
  logic [PFM_NUM_FNS-1:0] fn_high;
  logic [PFM_NUM_FNS-1:0] next_fn_in;
  logic [5:0] fn_pad [PFM_NUM_FNS];

  genvar gp, gf;
  generate
    for (gp = 0; gp < PFM_NUM_PADS; gp++) begin : g_pad
      logic [PFM_FL_W-1:0] fl;
      assign sel_ok[gp] = pad_sel[gp] <= PFM_SEL_MAX;
      assign sel_fn[gp] = sel_ok[gp] ? PFM_PAD_MAP[gp][pad_sel[gp]] : FN_NONE;
      assign fl = pfm_fn_flags(sel_fn[gp]);
      assign sel_in[gp] = fl[PFM_FL_IN];
      assign is_mtx[gp] = sel_fn[gp] == FN_MATRIX;
      // Plain outputs and clock outputs drive whenever selected
      assign dir_drive[gp] = fl[PFM_FL_OUT] &
        (fl[PFM_FL_TRI] ? fn_oe[sel_fn[gp]] : 1'h1);
      assign dir_val[gp] = fn_out[sel_fn[gp]];
      assign next_pad_out[gp] = is_mtx[gp] ? mtx_out_q[gp] :
        (dir_drive[gp] ? dir_val[gp] : PFM_RST_PAD_OUT);
      assign next_oe_b[gp] = is_mtx[gp] ? ~mtx_oe_q[gp] : ~dir_drive[gp];
      assign next_mtx_in[gp] = is_mtx[gp] ? pad_in[gp] : PFM_MTX_IDLE_IN;
    end
    for (gf = 0; gf < PFM_NUM_FNS; gf++) begin : g_fn
      logic [PFM_FL_W-1:0] ffl;
      assign ffl = pfm_fn_flags(pfm_fn_type'(gf));
      assign fn_high[gf] = ffl[PFM_FL_HIGH];
      assign next_fn_in[gf] = fn_hit[gf] ? pad_in[fn_pad[gf]] : fn_high[gf];
    end
  endgenerate

  // Lowest-numbered pad wins if several pick the same input function
  always_comb begin
    for (int f = 0; f < PFM_NUM_FNS; f++) begin
      fn_hit[f] = 1'h0;
      fn_pad[f] = 6'h0;
      for (int p = PFM_NUM_PADS - 1; p >= 0; p--) begin
        if (sel_fn[p] == pfm_fn_type'(f) && sel_in[p]) begin
          fn_hit[f] = 1'h1;
          fn_pad[f] = 6'(p);
        end
      end
    end
  end

  // Matrix stage: the extra register is the matrix latency
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mtx_out_q <= '0;
      mtx_oe_q <= '0;
      mtx_in_q <= '0;
      mtx_in <= '0;
    end else begin
      mtx_out_q <= mtx_out;
      mtx_oe_q <= mtx_oe;
      mtx_in_q <= next_mtx_in;
      mtx_in <= mtx_in_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pad_out <= '0;
      pad_oe_b <= '1;
      // Peripheral inputs sit at their idle level in reset
      fn_in <= fn_high;
    end else begin
      pad_out <= next_pad_out;
      pad_oe_b <= next_oe_b;
      fn_in <= next_fn_in;
    end
  end

  generate
    for (gp = 0; gp < PFM_NUM_PADS; gp++) begin : g_pad_chk
      property p_reserved_idle;
        @(posedge clk) disable iff (!rst_b)
          !sel_ok[gp] |=> pad_oe_b[gp] && !pad_out[gp];
      endproperty
      a_reserved_idle: assert property (p_reserved_idle)
        else $error("reserved select drove pad");

      property p_direct_drive;
        @(posedge clk) disable iff (!rst_b)
          (!is_mtx[gp] && dir_drive[gp]) |=> !pad_oe_b[gp] && pad_out[gp] == $past(dir_val[gp]);
      endproperty
      a_direct_drive: assert property (p_direct_drive)
        else $error("direct function not on pad after one cycle");

      property p_no_drive;
        @(posedge clk) disable iff (!rst_b)
          (!is_mtx[gp] && !dir_drive[gp]) |=> pad_oe_b[gp];
      endproperty
      a_no_drive: assert property (p_no_drive)
        else $error("pad driven without enabled output function");

      property p_matrix_latency;
        @(posedge clk) disable iff (!rst_b)
          (is_mtx[gp] && $past(is_mtx[gp]) && $past(rst_b)) |=>
            pad_out[gp] == $past(mtx_out[gp], 2) && pad_oe_b[gp] == !$past(mtx_oe[gp], 2);
      endproperty
      a_matrix_latency: assert property (p_matrix_latency)
        else $error("matrix path not two cycles");

      property p_clock_out;
        @(posedge clk) disable iff (!rst_b)
          (sel_fn[gp] inside {CK_OUT1, CK_OUT2, CK_OUT3}) |=> !pad_oe_b[gp];
      endproperty
      a_clock_out: assert property (p_clock_out)
        else $error("clock output not driven");

      property p_one_source;
        @(posedge clk) disable iff (!rst_b)
          !pad_oe_b[gp] |-> $past(sel_ok[gp]) && $past(sel_fn[gp]) != FN_NONE;
      endproperty
      a_one_source: assert property (p_one_source)
        else $error("pad driven with no function selected");

      property p_debug_input;
        @(posedge clk) disable iff (!rst_b)
          (sel_fn[gp] inside {DBG_CLK, DBG_DIN, DBG_MS}) |=> pad_oe_b[gp];
      endproperty
      a_debug_input: assert property (p_debug_input)
        else $error("debug input drove its pad");

      property p_strobe_release;
        @(posedge clk) disable iff (!rst_b)
          (sel_fn[gp] inside {MEM_DQS, FST_DQS} && !fn_oe[sel_fn[gp]]) |=> pad_oe_b[gp];
      endproperty
      a_strobe_release: assert property (p_strobe_release)
        else $error("strobe held pad without enable");

      property p_diff_clock;
        @(posedge clk) disable iff (!rst_b)
          (sel_fn[gp] inside {MEM_CLKN, MEM_CLKP, AUX_CLKN, AUX_CLKP} && fn_oe[sel_fn[gp]])
            |=> !pad_oe_b[gp] && pad_out[gp] == $past(fn_out[sel_fn[gp]]);
      endproperty
      a_diff_clock: assert property (p_diff_clock)
        else $error("differential clock half not on pad");

      property p_bus_input;
        @(posedge clk) disable iff (!rst_b)
          (sel_fn[gp] inside {MEM_DIN, AUX_DIN, FST_DIN})
            |=> fn_in[$past(sel_fn[gp])] == $past(pad_in[gp]);
      endproperty
      a_bus_input: assert property (p_bus_input)
        else $error("bus data input not following pad");
    end
    for (gf = 0; gf < PFM_NUM_FNS; gf++) begin : g_fn_chk
      property p_idle_input;
        @(posedge clk) disable iff (!rst_b)
          !fn_hit[gf] |=> fn_in[gf] == fn_high[gf];
      endproperty
      a_idle_input: assert property (p_idle_input)
        else $error("unselected input not at idle level");

      property p_follow_input;
        @(posedge clk) disable iff (!rst_b)
          fn_hit[gf] |=> fn_in[gf] == $past(pad_in[fn_pad[gf]]);
      endproperty
      a_follow_input: assert property (p_follow_input)
        else $error("selected input not following pad");
    end
  endgenerate

  property p_mtx_in_gate;
    @(posedge clk) disable iff (!rst_b)
      (!is_mtx[0] ##1 rst_b) |=> !mtx_in[0];
  endproperty
  a_mtx_in_gate: assert property (p_mtx_in_gate)
    else $error("matrix input seen while pad not routed to matrix");

  c_matrix: cover property (@(posedge clk) disable iff (!rst_b) is_mtx[0] ##1 !pad_oe_b[0]);
  c_mem_octal: cover property (@(posedge clk) disable iff (!rst_b)
    sel_fn[26] == MEM_UP4 && sel_fn[30] == MEM_DQS);
  c_clock_out: cover property (@(posedge clk) disable iff (!rst_b)
    sel_fn[19] == CK_OUT1 ##1 !pad_oe_b[19]);
  c_debug_in: cover property (@(posedge clk) disable iff (!rst_b)
    fn_hit[DBG_CLK] ##1 !fn_in[DBG_CLK]);

endmodule

// file: bench/pfm_pad_env.sv
`timescale 1ns/1ps
module pfm_pad_env
  import pfm_pkg::*;
(
  input wire logic clk,
  input wire logic [PFM_NUM_PADS-1:0] pad_out,
  input wire logic [PFM_NUM_PADS-1:0] pad_oe_b,
  input wire logic [PFM_NUM_PADS-1:0] ext_en,
  input wire logic [PFM_NUM_PADS-1:0] ext_val,
  output logic [PFM_NUM_PADS-1:0] pad_in
);
  // Undriven pads wander, never hold a stale level
  logic [PFM_NUM_PADS-1:0] float_lvl = '0;
  always_ff @(posedge clk) begin
    float_lvl <= ~float_lvl;
  end
  assign pad_in = (~pad_oe_b & pad_out) | (pad_oe_b & ext_en & ext_val)
    | (pad_oe_b & ~ext_en & float_lvl);
endmodule

// file: bench/pad_function_mux_bench.sv
`timescale 1ns/1ps
module pad_function_mux_bench
  import pfm_pkg::*;
;
  localparam logic [63:0] ALL_PADS = {PFM_NUM_PADS{1'b1}};
  // Idle-high inputs: serial rx/cts, debug inputs, bus data lines, fast port clock/select
  localparam logic [63:0] IDLE_HIGH = 64'h0000_1ff8_78f3_eea8;
  logic clk = 0;
  logic rst_b = 0;
  logic [PFM_SEL_W-1:0] pad_sel [PFM_NUM_PADS];
  logic [PFM_NUM_PADS-1:0] pad_in, pad_out, pad_oe_b, mtx_in;
  logic [PFM_NUM_PADS-1:0] mtx_out, mtx_oe, ext_en, ext_val;
  logic [PFM_NUM_FNS-1:0] fn_out, fn_oe, fn_in;
  int mismatches = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  pfm_pad_function_selector dut (.clk(clk), .rst_b(rst_b), .pad_sel(pad_sel),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_b(pad_oe_b), .fn_out(fn_out),
    .fn_oe(fn_oe), .fn_in(fn_in), .mtx_out(mtx_out), .mtx_oe(mtx_oe), .mtx_in(mtx_in));
  pfm_pad_env env (.clk(clk), .pad_out(pad_out), .pad_oe_b(pad_oe_b),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    rst_b = 0;
    cyc(2);
    chk("oe_b rst", pad_oe_b, ALL_PADS);
    chk("out rst", pad_out, 0);
    chk("fn_in rst", fn_in, IDLE_HIGH);
    chk("mtx_in rst", mtx_in, 0);
    rst_b = 1;
    cyc();
    chk("oe_b idle", pad_oe_b, ALL_PADS);
    chk("fn_in idle", fn_in, IDLE_HIGH);
    chk("rx idle", fn_in[S0_RX], 1);
    chk("tck idle", fn_in[DBG_CLK], 1);
    chk("dqs idle", fn_in[MEM_DQS], 0);
  endtask
  task automatic out_chk(input int p, input logic [2:0] s, input pfm_fn_type f,
    input logic only);
    pad_sel[p] = s;
    fn_out[f] = 1;
    cyc();
    chk("oe_b off", pad_oe_b[p], !only);
    chk("out off", pad_out[p], only);
    fn_oe[f] = 1;
    cyc();
    chk("oe_b on", pad_oe_b[p], 0);
    chk("out on", pad_out[p], 1);
    fn_out[f] = 0;
    cyc();
    chk("out low", pad_out[p], 0);
    pad_sel[p] = 3'h5;
    fn_oe[f] = 0;
    cyc();
    chk("oe_b free", pad_oe_b[p], 1);
  endtask
  task automatic in_chk(input int p, input logic [2:0] s, input pfm_fn_type f,
    input logic hi);
    pad_sel[p] = s;
    ext_en[p] = 1;
    ext_val[p] = 0;
    cyc();
    chk("in low", fn_in[f], 0);
    ext_val[p] = 1;
    cyc();
    chk("in high", fn_in[f], 1);
    ext_val[p] = 0;
    pad_sel[p] = 3'h5;
    cyc();
    chk("in idle", fn_in[f], hi);
    ext_en[p] = 0;
  endtask
  task automatic t_matrix();
    pad_sel[0] = 3'h0;
    mtx_out[0] = 1;
    mtx_oe[0] = 1;
    cyc();
    chk("mtx lag", pad_oe_b[0], 1);
    cyc();
    chk("mtx oe_b", pad_oe_b[0], 0);
    chk("mtx out", pad_out[0], 1);
    mtx_oe[0] = 0;
    ext_en[0] = 1;
    ext_val[0] = 0;
    cyc(4);
    chk("mtx in0", mtx_in[0], 0);
    ext_val[0] = 1;
    cyc();
    chk("mtx in lag", mtx_in[0], 0);
    cyc();
    chk("mtx in1", mtx_in[0], 1);
    pad_sel[0] = 3'h2;
    mtx_oe[0] = 1;
    cyc(2);
    chk("mtx gone", mtx_in[0], 0);
    chk("mtx off", pad_oe_b[0], 1);
    pad_sel[0] = 3'h5;
    mtx_out[0] = 0;
    mtx_oe[0] = 0;
    ext_en[0] = 0;
  endtask
  task automatic t_reserved();
    fn_out[MEM_DOUT] = 1;
    fn_oe[MEM_DOUT] = 1;
    mtx_out[24] = 1;
    mtx_oe[24] = 1;
    ext_en[25] = 1;
    for (int s = 5; s < 8; s++) begin
      pad_sel[24] = 3'(s);
      pad_sel[25] = 3'(s);
      cyc(2);
      chk("rsv oe_b", pad_oe_b[24], 1);
      chk("rsv out", pad_out[24], 0);
      chk("rsv din", fn_in[MEM_DIN], 1);
    end
    fn_out = '0;
    fn_oe = '0;
    mtx_out = '0;
    mtx_oe = '0;
    ext_en = '0;
  endtask
  initial begin
    pad_sel = '{default: 3'h5};
    fn_out = '0;
    fn_oe = '0;
    mtx_out = '0;
    mtx_oe = '0;
    ext_en = '0;
    ext_val = '0;
    t_reset();
    out_chk(35, 3'h0, S0_TX, 1);
    out_chk(19, 3'h3, CK_OUT1, 1);
    out_chk(18, 3'h3, CK_OUT2, 1);
    out_chk(17, 3'h3, CK_OUT3, 1);
    out_chk(32, 3'h0, DBG_DOUT, 0);
    out_chk(24, 3'h0, MEM_DOUT, 0);
    out_chk(30, 3'h4, MEM_DQS, 0);
    out_chk(37, 3'h0, MEM_CLKP, 0);
    out_chk(38, 3'h0, MEM_CLKN, 0);
    out_chk(37, 3'h2, AUX_CLKP, 0);
    out_chk(12, 3'h3, AUX_DOUT, 0);
    out_chk(12, 3'h4, FST_DOUT, 0);
    out_chk(12, 3'h2, FST_DQS, 0);
    in_chk(36, 3'h0, S0_RX, 1);
    in_chk(33, 3'h0, DBG_DIN, 1);
    in_chk(31, 3'h0, DBG_CLK, 1);
    in_chk(25, 3'h0, MEM_DIN, 1);
    in_chk(26, 3'h4, MEM_UP4, 1);
    in_chk(30, 3'h4, MEM_DQS, 0);
    in_chk(10, 3'h3, AUX_DIN, 1);
    in_chk(10, 3'h4, FST_DIN, 1);
    in_chk(8, 3'h2, FST_UP4, 1);
    t_matrix();
    t_reserved();
    t_reset();
    finish_test();
  end
  initial begin
    #5000;
    mismatches++;
    finish_test();
  end
endmodule
